// ==== design/jcp_pkg.sv ====
package jcp_pkg;

  localparam int unsigned INSTR_W = 32;
  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned GPR_AW  = 4;
  localparam int unsigned DPP_IW  = 2;

  localparam logic [ADDR_W-1:0]  RESET_ADDR  = 24'h000000;
  localparam logic [ADDR_W-1:0]  ADDR_STEP   = 24'h000001;
  localparam logic [INSTR_W-1:0] FILLER_WORD = 32'h00000000;

  // One instruction slot as it sits in the decode stage
  typedef struct packed {
    logic               valid;
    logic               inject;
    logic [ADDR_W-1:0]  addr;
    logic [INSTR_W-1:0] word;
  } jcp_slot_t;

  // Decoder's view of the instruction currently in decode
  typedef struct packed {
    logic              cache_jump;
    logic              std_branch;
    logic              taken;
    logic              csp_change;
    logic              cp_write;
    logic              dpp_write;
    logic [DPP_IW-1:0] dpp_idx;
    logic              gpr_use;
    logic              dpp_use;
    logic [DPP_IW-1:0] dpp_use_idx;
    logic              rd_en;
    logic [GPR_AW-1:0] rd_reg;
    logic              wr_en;
    logic [GPR_AW-1:0] wr_reg;
    logic [ADDR_W-1:0] target;
  } jcp_dec_info_t;

  // Control tag carried by execute and writeback stages
  typedef struct packed {
    logic              valid;
    logic              inject;
    logic              wr_en;
    logic [GPR_AW-1:0] wr_reg;
    logic              cp_write;
    logic              dpp_write;
    logic [DPP_IW-1:0] dpp_idx;
  } jcp_stage_t;

  typedef enum logic {
    FWD_REGFILE,
    FWD_WB
  } jcp_fwd_t;

  localparam jcp_slot_t  SLOT_EMPTY  = '0;
  localparam jcp_stage_t STAGE_EMPTY = '0;

endpackage : jcp_pkg

// ==== design/jcp_pipe_ctrl.sv ====
module jcp_pipe_ctrl (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          fetch_rvalid,
  input  wire logic [jcp_pkg::INSTR_W-1:0]   fetch_rdata,
  input  wire jcp_pkg::jcp_dec_info_t        dec_info,
  input  wire logic                          irq_take,
  output logic                               fetch_req_q,
  output logic [jcp_pkg::ADDR_W-1:0]         fetch_addr_q,
  output jcp_pkg::jcp_slot_t                 dec_q,
  output jcp_pkg::jcp_stage_t                ex_q,
  output jcp_pkg::jcp_stage_t                wb_q,
  output jcp_pkg::jcp_fwd_t                  fwd_sel_q,
  output logic                               stale_cp_q,
  output logic                               stale_dpp_q,
  output logic                               cache_hit_q,
  output logic                               cache_valid_q
);
  import jcp_pkg::*;

  logic               fetch_req_d;
  logic [ADDR_W-1:0]  fetch_addr_d;
  jcp_slot_t          dec_d;
  jcp_stage_t         ex_d;
  jcp_stage_t         wb_d;
  jcp_fwd_t           fwd_sel_d;
  logic               stale_cp_d;
  logic               stale_dpp_d;
  logic               cache_hit_d;
  logic               cache_valid_d;
  logic [ADDR_W-1:0]  cache_tag_q;
  logic [ADDR_W-1:0]  cache_tag_d;
  logic [ADDR_W-1:0]  cache_tgt_q;
  logic [ADDR_W-1:0]  cache_tgt_d;
  logic [INSTR_W-1:0] cache_word_q;
  logic [INSTR_W-1:0] cache_word_d;
  logic               fill_pend_q;
  logic               fill_pend_d;
  logic [ADDR_W-1:0]  fill_tag_q;
  logic [ADDR_W-1:0]  fill_tag_d;

  logic dec_live;
  logic jump_taken;
  logic cj_taken;
  logic inval;
  logic hit;
  logic miss;
  logic fill_now;

  // Filler slots carry no decoder meaning
  assign dec_live   = dec_q.valid & ~dec_q.inject;
  assign jump_taken = dec_live & dec_info.taken & (dec_info.cache_jump | dec_info.std_branch);
  assign cj_taken   = dec_live & dec_info.taken & dec_info.cache_jump;
  assign inval      = irq_take | (dec_live & dec_info.csp_change);
  // Same-cycle interrupt also blocks the hit, keeping invalidation conservative
  assign hit        = cj_taken & cache_valid_q & (cache_tag_q == dec_q.addr) & ~inval;
  assign miss       = jump_taken & ~hit;
  assign fill_now   = fill_pend_q & fetch_rvalid & ~jump_taken;

  // Fetch and stage advance
  always_comb begin
    fetch_req_d  = 1'b1;
    fetch_addr_d = fetch_addr_q;
    dec_d        = SLOT_EMPTY;
    if (hit) begin
      // Cached target goes straight to decode; fetch resumes past it
      dec_d.valid  = 1'b1;
      dec_d.inject = 1'b0;
      dec_d.addr   = cache_tgt_q;
      dec_d.word   = cache_word_q;
      fetch_addr_d = cache_tgt_q + ADDR_STEP;
    end else if (jump_taken) begin
      // Word in flight is the fall-through; replace it with a filler
      dec_d.valid  = 1'b1;
      dec_d.inject = 1'b1;
      dec_d.addr   = dec_q.addr;
      dec_d.word   = FILLER_WORD;
      fetch_addr_d = dec_info.target;
    end else if (fetch_rvalid) begin
      // Untaken branches fall here and cost nothing extra
      dec_d.valid  = 1'b1;
      dec_d.inject = 1'b0;
      dec_d.addr   = fetch_addr_q;
      dec_d.word   = fetch_rdata;
      fetch_addr_d = fetch_addr_q + ADDR_STEP;
    end

    ex_d = STAGE_EMPTY;
    if (dec_q.valid) begin
      ex_d.valid     = 1'b1;
      ex_d.inject    = dec_q.inject;
      ex_d.wr_en     = dec_live & dec_info.wr_en;
      ex_d.wr_reg    = dec_info.wr_reg;
      ex_d.cp_write  = dec_live & dec_info.cp_write;
      ex_d.dpp_write = dec_live & dec_info.dpp_write;
      ex_d.dpp_idx   = dec_info.dpp_idx;
    end
    wb_d = ex_q;

    // Producer now in execute is in writeback when the consumer executes
    fwd_sel_d = FWD_REGFILE;
    if (dec_live && dec_info.rd_en && ex_q.valid && ex_q.wr_en
        && (ex_q.wr_reg == dec_info.rd_reg)) begin
      fwd_sel_d = FWD_WB;
    end

    // Pointer registers update in execute, too late for the next decode
    stale_cp_d  = dec_live & dec_info.gpr_use & ex_q.valid & ex_q.cp_write;
    stale_dpp_d = dec_live & dec_info.dpp_use & ex_q.valid & ex_q.dpp_write
                  & (ex_q.dpp_idx == dec_info.dpp_use_idx);
    cache_hit_d = hit;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetch_req_q  <= 1'b0;
      fetch_addr_q <= RESET_ADDR;
      dec_q        <= SLOT_EMPTY;
      ex_q         <= STAGE_EMPTY;
      wb_q         <= STAGE_EMPTY;
      fwd_sel_q    <= FWD_REGFILE;
      stale_cp_q   <= 1'b0;
      stale_dpp_q  <= 1'b0;
      cache_hit_q  <= 1'b0;
    end else begin
      fetch_req_q  <= fetch_req_d;
      fetch_addr_q <= fetch_addr_d;
      dec_q        <= dec_d;
      ex_q         <= ex_d;
      wb_q         <= wb_d;
      fwd_sel_q    <= fwd_sel_d;
      stale_cp_q   <= stale_cp_d;
      stale_dpp_q  <= stale_dpp_d;
      cache_hit_q  <= cache_hit_d;
    end
  end

  // Jump cache: one entry, filled from the target fetch after a cache jump miss
  always_comb begin
    cache_valid_d = cache_valid_q;
    cache_tag_d   = cache_tag_q;
    cache_tgt_d   = cache_tgt_q;
    cache_word_d  = cache_word_q;
    fill_pend_d   = fill_pend_q;
    fill_tag_d    = fill_tag_q;
    if (fill_now) begin
      cache_valid_d = 1'b1;
      cache_tag_d   = fill_tag_q;
      cache_tgt_d   = fetch_addr_q;
      cache_word_d  = fetch_rdata;
      fill_pend_d   = 1'b0;
    end
    if (miss && dec_info.cache_jump) begin
      // Old entry stays usable until the new target arrives
      fill_pend_d = 1'b1;
      fill_tag_d  = dec_q.addr;
    end else if (miss) begin
      fill_pend_d = 1'b0;
    end
    // Invalidation beats a fill landing in the same cycle
    if (inval) begin
      cache_valid_d = 1'b0;
      fill_pend_d   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cache_valid_q <= 1'b0;
      cache_tag_q   <= RESET_ADDR;
      cache_tgt_q   <= RESET_ADDR;
      cache_word_q  <= FILLER_WORD;
      fill_pend_q   <= 1'b0;
      fill_tag_q    <= RESET_ADDR;
    end else begin
      cache_valid_q <= cache_valid_d;
      cache_tag_q   <= cache_tag_d;
      cache_tgt_q   <= cache_tgt_d;
      cache_word_q  <= cache_word_d;
      fill_pend_q   <= fill_pend_d;
      fill_tag_q    <= fill_tag_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_filler_then_fetch;
    dec_q.valid && dec_q.inject && (fetch_addr_q == $past(dec_info.target));
  endsequence

  sequence s_down_the_pipe;
    ex_q.valid ##1 wb_q.valid;
  endsequence

  a_miss_filler: assert property (
    (miss && dec_info.cache_jump) |=> s_filler_then_fetch
  ) else $error("cache jump miss did not inject filler and redirect");

  a_fill_stores: assert property (
    (fill_now && !inval) |=> cache_valid_q && (cache_word_q == $past(fetch_rdata))
                             && (cache_tag_q == $past(fill_tag_q))
  ) else $error("target fetch was not stored in jump cache");

  a_branch_nofill: assert property (
    (miss && !dec_info.cache_jump) |=> !fill_pend_q
  ) else $error("standard branch armed a cache fill");

  a_hit_injects: assert property (
    hit |=> dec_q.valid && !dec_q.inject && (dec_q.word == $past(cache_word_q))
            && (dec_q.addr == $past(cache_tgt_q)) && cache_hit_q
  ) else $error("cache hit did not place cached target in decode");

  // A cached target that is itself a taken jump legally brings its own filler
  a_hit_one_cycle: assert property (
    hit |=> (fetch_addr_q == $past(cache_tgt_q) + ADDR_STEP)
            ##1 (!dec_q.inject || $past(jump_taken))
  ) else $error("cache hit cost more than one cycle");

  a_repeat_hits: assert property (
    (cj_taken && cache_valid_q && (cache_tag_q == dec_q.addr) && !inval)
    |=> cache_hit_q && dec_q.valid && !dec_q.inject
  ) else $error("valid matching entry was not used");

  a_segment_inval: assert property (
    (dec_live && dec_info.csp_change) |=> !cache_valid_q && !fill_pend_q
  ) else $error("segment change left jump cache valid");

  a_irq_inval: assert property (
    irq_take |=> !cache_valid_q ##1 (!cache_valid_q || $past(fill_now))
  ) else $error("interrupt left jump cache valid");

  a_stage_flow: assert property (
    dec_q.valid |=> s_down_the_pipe
  ) else $error("instruction did not advance one stage per cycle");

  a_fwd_select: assert property (
    (dec_live && dec_info.rd_en && ex_q.valid && ex_q.wr_en
     && (ex_q.wr_reg == dec_info.rd_reg)) |=> (fwd_sel_q == FWD_WB) && wb_q.wr_en
  ) else $error("dependent operand not forwarded");

  a_cp_window: assert property (
    stale_cp_q |-> $past(ex_q.cp_write) && ex_q.valid && wb_q.cp_write
  ) else $error("context pointer hazard flagged without a preceding write");

  a_dpp_window: assert property (
    stale_dpp_q |-> wb_q.dpp_write && (wb_q.dpp_idx == $past(dec_info.dpp_use_idx))
  ) else $error("page pointer hazard flagged for another pointer");

  a_branch_cost: assert property (
    (dec_live && dec_info.std_branch && !dec_info.taken && fetch_rvalid) |=> !dec_q.inject
  ) else $error("untaken branch injected a filler");

  a_tag_refill: assert property (
    (cj_taken && (cache_tag_q != dec_q.addr) && !inval) |=> dec_q.inject
                                                             && (fill_tag_q == $past(dec_q.addr))
  ) else $error("tag mismatch did not refill jump cache");

endmodule : jcp_pipe_ctrl

// ==== bench/jcp_prog_mem.sv ====
module jcp_prog_mem (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        slow,
  input  wire logic                        fetch_req_q,
  input  wire logic [jcp_pkg::ADDR_W-1:0]  fetch_addr_q,
  output logic                             fetch_rvalid,
  output logic [jcp_pkg::INSTR_W-1:0]      fetch_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import jcp_pkg::*;

  logic hold_q;

  // Slow mode answers every other cycle only
  always_ff @(posedge ref_clk) begin
    hold_q <= !sys_rst && slow && !hold_q;
  end

  assign fetch_rvalid = fetch_req_q && !hold_q;
  // Idle bus shows the inverted word, so a missed answer cannot look right
  assign fetch_rdata  = fetch_rvalid ? {8'h5A, fetch_addr_q} : ~{8'h5A, fetch_addr_q};
endmodule : jcp_prog_mem

// ==== bench/jcp_pipe_ctrl_tb.sv ====
module jcp_pipe_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import jcp_pkg::*;

  logic                ref_clk  = 1'b0;
  logic                sys_rst  = 1'b1;
  logic                slow     = 1'b0;
  logic                irq_take = 1'b0;
  logic                fetch_rvalid, fetch_req_q, stale_cp_q, stale_dpp_q;
  logic                cache_hit_q, cache_valid_q;
  logic [INSTR_W-1:0]  fetch_rdata;
  logic [ADDR_W-1:0]   fetch_addr_q;
  jcp_dec_info_t       dec_info;
  jcp_dec_info_t       prog [0:31];
  jcp_slot_t           dec_q;
  jcp_stage_t          ex_q, wb_q;
  jcp_fwd_t            fwd_sel_q;
  int                  err_total = 0;
  int                  checks    = 0;

  always #5 ref_clk = ~ref_clk;

  jcp_prog_mem i_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
    .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q),
    .fetch_rvalid(fetch_rvalid), .fetch_rdata(fetch_rdata));

  jcp_pipe_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_rvalid(fetch_rvalid),
    .fetch_rdata(fetch_rdata), .dec_info(dec_info), .irq_take(irq_take),
    .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .dec_q(dec_q), .ex_q(ex_q),
    .wb_q(wb_q), .fwd_sel_q(fwd_sel_q), .stale_cp_q(stale_cp_q), .stale_dpp_q(stale_dpp_q),
    .cache_hit_q(cache_hit_q), .cache_valid_q(cache_valid_q));

  // Decoder model: a program table indexed by the decode address
  always_comb begin
    dec_info = '0;
    if (dec_q.valid === 1'b1 && dec_q.inject === 1'b0) begin
      dec_info = prog[dec_q.addr[4:0]];
    end
  end

  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [INSTR_W-1:0] seen,
                     input logic [INSTR_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic restart(input int n);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    prog    <= '{default: '0};
    repeat (n) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : restart

  // Bounded wait until the given address sits in decode as a fetched word
  task automatic wait_dec(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < 64; i++) begin
      step();
      if (dec_q.valid === 1'b1 && dec_q.inject === 1'b0 && dec_q.addr === a) return;
    end
    err_total++;
    $display("Error wait_dec expected %h seen timeout", a);
    test_done();
  endtask : wait_dec

  task automatic jump_at(input logic [ADDR_W-1:0] a, input logic hit);
    wait_dec(a);
    step();
    chk("cache_hit_q", cache_hit_q, hit);
    chk("dec_q.inject", dec_q.inject, !hit);
  endtask : jump_at

  function automatic jcp_dec_info_t br(input logic cj, input logic [ADDR_W-1:0] t);
    br            = '0;
    br.cache_jump = cj;
    br.std_branch = !cj;
    br.taken      = 1'b1;
    br.target     = t;
  endfunction : br

  task automatic t_seq();
    logic [ADDR_W-1:0] a;
    logic              pd;
    logic              pe;
    a  = RESET_ADDR;
    pd = 1'b0;
    pe = 1'b0;
    slow <= 1'b1;
    restart(2);
    for (int i = 0; i < 20; i++) begin
      step();
      chk("ex_q.valid", ex_q.valid, pd);
      chk("wb_q.valid", wb_q.valid, pe);
      chk("fetch_req_q", fetch_req_q, 1'b1);
      if (dec_q.valid === 1'b1) begin
        chk("dec_q.addr", dec_q.addr, a);
        chk("dec_q.word", dec_q.word, {8'h5A, a});
        a = a + ADDR_STEP;
      end
      pd = dec_q.valid;
      pe = ex_q.valid;
    end
    // Stalled memory must leave bubbles, about half the slots
    chk("words taken", a inside {[5:11]}, 1'b1);
    slow <= 1'b0;
    $display("t_seq done");
  endtask : t_seq

  task automatic t_cache();
    restart(2);
    prog[4] = br(1'b1, 24'h000002);
    wait_dec(24'h000004);
    step();
    chk("dec_q.inject", dec_q.inject, 1'b1);
    step();
    chk("dec_q.addr", dec_q.addr, 24'h000002);
    chk("cache_valid_q", cache_valid_q, 1'b1);
    chk("ex_q.inject", ex_q.inject, 1'b1);
    jump_at(24'h000004, 1'b1);
    chk("dec_q.word", dec_q.word, 32'h5A000002);
    chk("fetch_addr_q", fetch_addr_q, 24'h000003);
    prog[3].csp_change = 1'b1;
    jump_at(24'h000004, 1'b0);
    prog[3].csp_change = 1'b0;
    jump_at(24'h000004, 1'b1);
    irq_take <= 1'b1;
    step();
    irq_take <= 1'b0;
    chk("cache_valid_q", cache_valid_q, 1'b0);
    jump_at(24'h000004, 1'b0);
    prog[4].taken = 1'b0;
    prog[6] = br(1'b1, 24'h000002);
    wait_dec(24'h000004);
    step();
    chk("dec_q.addr", dec_q.addr, 24'h000005);
    chk("dec_q.inject", dec_q.inject, 1'b0);
    jump_at(24'h000006, 1'b0);
    jump_at(24'h000006, 1'b1);
    $display("t_cache done");
  endtask : t_cache

  task automatic t_branch();
    restart(2);
    prog[3]       = br(1'b0, 24'h000010);
    prog[3].taken = 1'b0;
    prog[4]       = br(1'b0, 24'h000002);
    jump_at(24'h000004, 1'b0);
    step();
    chk("dec_q.addr", dec_q.addr, 24'h000002);
    chk("cache_valid_q", cache_valid_q, 1'b0);
    jump_at(24'h000004, 1'b0);
    $display("t_branch done");
  endtask : t_branch

  task automatic t_hazard();
    restart(2);
    prog[1].cp_write     = 1'b1;
    prog[2].gpr_use      = 1'b1;
    prog[3].cp_write     = 1'b1;
    prog[5].gpr_use      = 1'b1; // Address 4 is the spacer
    prog[6].dpp_write    = 1'b1;
    prog[6].dpp_idx      = 2'h2;
    prog[8].dpp_use      = 1'b1; // Address 7 is the spacer
    prog[8].dpp_use_idx  = 2'h2;
    prog[9].dpp_write    = 1'b1;
    prog[9].dpp_idx      = 2'h2;
    prog[10].dpp_use     = 1'b1;
    prog[10].dpp_use_idx = 2'h2;
    prog[11].dpp_write   = 1'b1;
    prog[11].dpp_idx     = 2'h1;
    prog[12].dpp_use     = 1'b1;
    prog[12].dpp_use_idx = 2'h2;
    prog[13].wr_en       = 1'b1;
    prog[13].wr_reg      = 4'h3;
    prog[14].rd_en       = 1'b1;
    prog[14].rd_reg      = 4'h3;
    prog[15].rd_en       = 1'b1;
    prog[15].rd_reg      = 4'h5;
    wait_dec(24'h000001);
    for (int k = 1; k < 16; k++) begin
      step();
      chk("stale_cp_q", stale_cp_q, k == 2);
      chk("stale_dpp_q", stale_dpp_q, k == 10);
      chk("fwd_sel_q", fwd_sel_q, k == 14);
    end
    $display("t_hazard done");
  endtask : t_hazard

  initial begin
    prog = '{default: '0};
    restart(11);
    t_seq();
    t_cache();
    t_branch();
    t_hazard();
    test_done();
  end
endmodule : jcp_pipe_ctrl_tb
